// ==== rtl/eerk_dev.sv ====
/*
 Memory device end: two-wire slave serving the EEPROM array, the
 protected block with its two-key unlock, and an address-only window
 onto the clock/SRAM space sharing one pointer.
 Assumes the bus lines arrive unsynchronised from the link.
*/
// The implementer's own choices: the register addresses and the plain strobed port.
// Function
// - Pointer holds last accessed location plus one
// - Read control byte: ack, then send byte
// - Master nack and stop end read; release
// - One pointer shared by both address spaces
// - Random read: address write, restart, read
// - Restart after address aborts write, keeps pointer
// - After random read pointer follows byte read
// - Master ack requests next sequential byte
// - Pointer advances after every byte operation
// - Array read wraps top location to first
// - Protected block F0-F7 under EEPROM code
// - Protected block readable without unlocking
// - Invalid address byte is not acknowledged
// - Unlock key has no storage, reads zero
// - Keys 0x55 then 0xAA enable protected write
// - Wrong key order keeps lock, discards write
// - Block relocks after every write to the protected block
// - Partial writes of protected block allowed
// - Six-byte identifier at F2 to F7
// - Eight-byte identifier at F0 to F7
// - EEPROM commands refused during write cycle
`timescale 1ns/1ns
module eerk_dev #(
    parameter int WRITE_CYCLES = eerk_pkg::WRITE_CYCLES,
    parameter int ID_KIND = eerk_pkg::ID_NONE,
    // Arbitrary identifier value
    parameter logic [63:0] NODE_ID = 64'h0A1B2C_0102030405
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Link
    eerk_if.dev bus,
    // Status
    output logic [7:0] addr_pointer,
    output logic prot_unlocked,
    output logic write_busy
);
    typedef enum logic [6:0] {
        D_IDLE = 7'h01,
        D_CTRL = 7'h02,
        D_ADDR = 7'h04,
        D_WDATA = 7'h08,
        D_ACK = 7'h10,
        D_RDATA = 7'h20,
        D_MACK = 7'h40
    } eerk_dstate_t;

    typedef logic [eerk_pkg::MEM_DEPTH-1:0][7:0] eerk_mem_t;

    typedef struct packed {
        logic [1:0] line;
        eerk_dstate_t st;
        eerk_dstate_t after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rtc;
        logic [7:0] ptr;
        logic sda_oe;
        logic [7:0][7:0] pbuf;
        logic [7:0] pmask;
        logic key_half;
        logic unlocked;
        logic [31:0] busy_cnt;
        logic wbusy;
        eerk_mem_t mem;
    } eerk_ds_t;

    eerk_ds_t s;
    eerk_ds_t next_s;
    logic [1:0] pins;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [6:0] code;

    ////////////////////////////////////////////////////////////////////
    // Pointer step after a byte, with the wrap of each region
    function automatic logic [7:0] step(input logic rtc, input logic [7:0] a);
        if (rtc) begin
            if (a == eerk_pkg::RTC_TIME_LAST) begin
                return 8'h00;
            end
            if (a == eerk_pkg::RTC_LAST) begin
                return eerk_pkg::RTC_SRAM_FIRST;
            end
            return 8'(a + 8'h01);
        end
        if (a == eerk_pkg::ARRAY_LAST) begin
            return 8'h00;
        end
        if (a == eerk_pkg::PROT_LAST) begin
            return eerk_pkg::PROT_FIRST;
        end
        return 8'(a + 8'h01);
    endfunction

    function automatic logic valid(input logic rtc, input logic [7:0] a);
        if (rtc) begin
            return a <= eerk_pkg::RTC_LAST;
        end
        return a <= eerk_pkg::ARRAY_LAST
            || (a >= eerk_pkg::PROT_FIRST && a <= eerk_pkg::PROT_LAST);
    endfunction

    // Storage slot: array first, protected block above it
    function automatic logic [7:0] slot(input logic [7:0] a);
        if (a[7]) begin
            return 8'(eerk_pkg::ARRAY_DEPTH) + {5'h00, a[2:0]};
        end
        return {1'b0, a[6:0]};
    endfunction

    // Erased contents with the factory identifier in the protected block
    function automatic eerk_mem_t init_mem();
        eerk_mem_t m;
        m = {eerk_pkg::MEM_DEPTH{eerk_pkg::ERASED}};
        for (int i = 0; i < 8; i++) begin
            if (ID_KIND == eerk_pkg::ID_64) begin
                m[eerk_pkg::ARRAY_DEPTH + i] = NODE_ID[63 - 8 * i -: 8];
            end else if (ID_KIND == eerk_pkg::ID_48 && i >= 2) begin
                m[eerk_pkg::ARRAY_DEPTH + i] = NODE_ID[63 - 8 * i -: 8];
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    eerk_sync #(.W(2)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .din({bus.scl, bus.sda}),
        .dout(pins)
    );

    assign scl = pins[1];
    assign sda = pins[0];
    assign rise = scl && !s.line[1];
    assign fall = !scl && s.line[1];
    assign start = scl && s.line[1] && s.line[0] && !sda;
    assign stop = scl && s.line[1] && !s.line[0] && sda;
    assign code = s.sh[7:1];

    always_comb begin
        next_s = s;
        next_s.line = {scl, sda};
        if (s.busy_cnt != 32'h0) begin
            next_s.busy_cnt = s.busy_cnt - 32'h1;
        end
        if (start) begin
            // A restart drops any buffered data; the pointer stays loaded
            next_s.st = D_CTRL;
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b0;
            next_s.pmask = 8'h00;
        end else if (stop) begin
            next_s.st = D_IDLE;
            next_s.sda_oe = 1'b0;
            if (!s.rtc && s.pmask != 8'h00) begin
                if (!s.ptr[7] || s.unlocked) begin
                    for (int i = 0; i < 8; i++) begin
                        if (s.pmask[i]) begin
                            next_s.mem[slot({s.ptr[7:3], 3'(i)})] = s.pbuf[i];
                        end
                    end
                    next_s.busy_cnt = 32'(WRITE_CYCLES);
                end
                if (s.ptr[7]) begin
                    next_s.unlocked = 1'b0;
                    next_s.key_half = 1'b0;
                end
            end
            next_s.pmask = 8'h00;
        end else begin
            case (s.st)
                D_CTRL, D_ADDR, D_WDATA: begin
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], sda};
                        next_s.cnt = 4'(s.cnt + 4'h1);
                    end
                    if (fall && s.cnt == 4'h8) begin
                        next_s.cnt = 4'h0;
                        next_s.st = D_IDLE;
                        next_s.after = D_WDATA;
                        case (s.st)
                            D_CTRL: begin
                                if (code == eerk_pkg::CODE_RTC
                                    || (code == eerk_pkg::CODE_EE
                                    && s.busy_cnt == 32'h0)) begin
                                    next_s.rtc = code == eerk_pkg::CODE_RTC;
                                    next_s.sda_oe = 1'b1;
                                    next_s.st = D_ACK;
                                    next_s.after = s.sh[0] ? D_RDATA : D_ADDR;
                                end
                            end
                            D_ADDR: begin
                                if (valid(s.rtc, s.sh)) begin
                                    next_s.ptr = s.sh;
                                    next_s.sda_oe = 1'b1;
                                    next_s.st = D_ACK;
                                end
                            end
                            default: begin
                                next_s.sda_oe = 1'b1;
                                next_s.st = D_ACK;
                                if (s.rtc) begin
                                    if (s.ptr == eerk_pkg::KEY_ADDR) begin
                                        next_s.key_half = s.sh == eerk_pkg::KEY_FIRST;
                                        next_s.unlocked = s.key_half
                                            && s.sh == eerk_pkg::KEY_SECOND;
                                    end
                                    next_s.ptr = step(1'b1, s.ptr);
                                end else begin
                                    next_s.pbuf[s.ptr[2:0]] = s.sh;
                                    next_s.pmask[s.ptr[2:0]] = 1'b1;
                                    next_s.ptr = {s.ptr[7:3], 3'(s.ptr[2:0] + 3'h1)};
                                end
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    if (fall) begin
                        next_s.st = s.after;
                        next_s.sda_oe = 1'b0;
                        if (s.after == D_RDATA) begin
                            // Key register and clock space read as zero
                            next_s.sh = s.rtc ? 8'h00 : s.mem[slot(s.ptr)];
                            next_s.sda_oe = s.rtc ? 1'b1 : !s.mem[slot(s.ptr)][7];
                            next_s.cnt = 4'h0;
                        end
                    end
                end
                D_RDATA: begin
                    if (rise) begin
                        next_s.cnt = 4'(s.cnt + 4'h1);
                    end
                    if (fall) begin
                        if (s.cnt == 4'h8) begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = D_MACK;
                            next_s.ptr = step(s.rtc, s.ptr);
                        end else begin
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.sda_oe = !s.sh[6];
                        end
                    end
                end
                D_MACK: begin
                    if (rise) begin
                        next_s.after = D_RDATA;
                        next_s.st = sda ? D_IDLE : D_ACK;
                    end
                end
                default: next_s.st = D_IDLE;
            endcase
        end
        next_s.wbusy = next_s.busy_cnt != 32'h0;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.line <= 2'b11;
            s.st <= D_IDLE;
            s.after <= D_IDLE;
            s.mem <= init_mem();
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = s.sda_oe;
    assign addr_pointer = s.ptr;
    assign prot_unlocked = s.unlocked;
    assign write_busy = s.wbusy;
endmodule

// ==== rtl/eerk_pkg.sv ====
/*
 Shared constants for the protected-EEPROM read and unlock link:
 bus codes, address map, key values, timing and controller registers.
 Assumes a 100 MHz system clock on both ends.
*/
package eerk_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCL_HZ = 400_000;
    // Quarter of an SCL period, rounded up so the bus never runs fast
    localparam int SCL_QUARTER = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    ////////////////////////////////////////////////////////////////////
    localparam logic [6:0] CODE_EE = 7'h57;
    localparam logic [6:0] CODE_RTC = 7'h6F;
    localparam logic [7:0] ARRAY_LAST = 8'h7F;
    localparam logic [7:0] PROT_FIRST = 8'hF0;
    localparam logic [7:0] PROT_LAST = 8'hF7;
    localparam logic [7:0] RTC_TIME_LAST = 8'h1F;
    localparam logic [7:0] RTC_SRAM_FIRST = 8'h20;
    localparam logic [7:0] RTC_LAST = 8'h5F;
    localparam logic [7:0] KEY_ADDR = 8'h09;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam int ARRAY_DEPTH = 128;
    localparam int MEM_DEPTH = 136;
    localparam int ID_NONE = 0;
    localparam int ID_48 = 1;
    localparam int ID_64 = 2;
    ////////////////////////////////////////////////////////////////////
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_TX = 2'h1;
    localparam logic [1:0] REG_RX = 2'h2;
    localparam logic [1:0] REG_STAT = 2'h3;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_WRITE = 2;
    localparam int CMD_READ = 3;
    localparam int CMD_NACK = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_NACK = 1;
endpackage

// ==== rtl/eerk_if.sv ====
/*
 Two-wire link between the bus controller and the memory device.
 Lines are open drain with pull-ups; the level is resolved here.
*/
`timescale 1ns/1ns
interface eerk_if;
    logic scl_o;
    logic scl_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;

    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

    modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
    modport dev (output sda_d_o, sda_d_oe, input scl, sda);
endinterface

// ==== rtl/eerk_sync.sv ====
/*
 Two-stage synchroniser for levels from outside the clock domain.
 Assumes inputs idle high, as pulled-up bus lines do.
*/
`timescale 1ns/1ns
module eerk_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '1;
            dout <= '1;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ==== rtl/eerk_host.sv ====
/*
 Bus controller: runs start, byte and stop phases on the two-wire link
 as ordered through a small register port, and drives SCL by a divider.
 Assumes a device that never stretches the clock.
*/
`timescale 1ns/1ns
module eerk_host #(
    parameter int QUARTER = eerk_pkg::SCL_QUARTER
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Link
    eerk_if.host bus
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_START = 4'h2,
        H_BITS = 4'h4,
        H_STOP = 4'h8
    } eerk_hstate_t;

    typedef struct packed {
        eerk_hstate_t st;
        logic [1:0] ph;
        logic [7:0] tick;
        logic [3:0] bitn;
        logic [4:0] cmd;
        logic [7:0] txreg;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] rxreg;
        logic got_nack;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rdata;
    } eerk_hs_t;

    eerk_hs_t s;
    eerk_hs_t next_s;
    logic sda_in;

    eerk_sync #(.W(1)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .din(bus.sda),
        .dout(sda_in)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                eerk_pkg::REG_TX: next_s.rdata = s.txreg;
                eerk_pkg::REG_RX: next_s.rdata = s.rxreg;
                eerk_pkg::REG_STAT: next_s.rdata = {6'h00, s.got_nack, s.st != H_IDLE};
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (reg_wr && reg_addr == eerk_pkg::REG_TX) begin
            next_s.txreg = reg_wdata;
        end
        // Commands while a sequence runs are ignored
        if (reg_wr && reg_addr == eerk_pkg::REG_CMD && s.st == H_IDLE) begin
            next_s.cmd = reg_wdata[4:0];
            next_s.ph = 2'd0;
            next_s.tick = 8'h00;
            next_s.bitn = 4'h0;
            next_s.tx = s.txreg;
            next_s.got_nack = 1'b0;
            if (reg_wdata[eerk_pkg::CMD_START]) begin
                next_s.st = H_START;
            end else if (reg_wdata[eerk_pkg::CMD_WRITE] || reg_wdata[eerk_pkg::CMD_READ]) begin
                next_s.st = H_BITS;
            end else if (reg_wdata[eerk_pkg::CMD_STOP]) begin
                next_s.st = H_STOP;
            end
        end else if (s.st != H_IDLE) begin
            next_s.tick = 8'(s.tick + 8'h01);
            if (s.tick == 8'(QUARTER - 1)) begin
                next_s.tick = 8'h00;
                next_s.ph = 2'(s.ph + 2'd1);
                case (s.st)
                    H_START: begin
                        // Works from idle and as a repeated start with SCL low
                        case (s.ph)
                            2'd0: next_s.sda_oe = 1'b0;
                            2'd1: next_s.scl_oe = 1'b0;
                            2'd2: next_s.sda_oe = 1'b1;
                            default: begin
                                next_s.scl_oe = 1'b1;
                                if (s.cmd[eerk_pkg::CMD_WRITE] || s.cmd[eerk_pkg::CMD_READ]) begin
                                    next_s.st = H_BITS;
                                end else if (s.cmd[eerk_pkg::CMD_STOP]) begin
                                    next_s.st = H_STOP;
                                end else begin
                                    next_s.st = H_IDLE;
                                end
                            end
                        endcase
                    end
                    H_BITS: begin
                        case (s.ph)
                            2'd0: begin
                                if (s.bitn == 4'h8) begin
                                    // Ack or withheld ack after a read byte
                                    next_s.sda_oe = s.cmd[eerk_pkg::CMD_READ]
                                        && !s.cmd[eerk_pkg::CMD_NACK];
                                end else begin
                                    next_s.sda_oe = s.cmd[eerk_pkg::CMD_WRITE]
                                        && !s.tx[7];
                                end
                            end
                            2'd1: next_s.scl_oe = 1'b0;
                            2'd2: begin
                                if (s.bitn != 4'h8) begin
                                    next_s.rx = {s.rx[6:0], sda_in};
                                end else if (s.cmd[eerk_pkg::CMD_WRITE]) begin
                                    next_s.got_nack = sda_in;
                                end
                            end
                            default: begin
                                next_s.scl_oe = 1'b1;
                                next_s.tx = {s.tx[6:0], 1'b0};
                                next_s.bitn = 4'(s.bitn + 4'h1);
                                if (s.bitn == 4'h8) begin
                                    next_s.sda_oe = 1'b0;
                                    next_s.rxreg = s.cmd[eerk_pkg::CMD_READ] ? s.rx : s.rxreg;
                                    next_s.st = s.cmd[eerk_pkg::CMD_STOP] ? H_STOP : H_IDLE;
                                end
                            end
                        endcase
                    end
                    H_STOP: begin
                        case (s.ph)
                            2'd0: next_s.sda_oe = 1'b1;
                            2'd1: next_s.scl_oe = 1'b0;
                            2'd2: next_s.sda_oe = 1'b0;
                            default: next_s.st = H_IDLE;
                        endcase
                    end
                    default: next_s.st = H_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= H_IDLE;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign reg_rdata = s.rdata;
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = s.scl_oe;
    assign bus.sda_h_o = 1'b0;
    assign bus.sda_h_oe = s.sda_oe;
endmodule

// ==== bench/eerk_props.sv ====
/*
 Link checker beside the interface joining controller and device.
 Assumes a quarter phase of 4 to 21 clock cycles.
*/
`timescale 1ns/1ns
module eerk_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_h_o,
    input wire logic sda_h_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_open_drain; !scl_o && !sda_h_o && !sda_d_o; endproperty
    property p_dev_on_low; $changed(sda_d_oe) |-> !scl; endproperty
    property p_ack_span; $rose(sda_d_oe) |-> ##[1:40] (scl && sda_d_oe); endproperty
    property p_ack_delay;
        $rose(sda_d_oe) |-> !scl && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5));
    endproperty
    property p_start_free; scl && $fell(sda) |-> !sda_d_oe; endproperty
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    property p_wire_low; (sda_d_oe || sda_h_oe) |-> !sda; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    a_dev_on_low: assert property (p_dev_on_low) else $error("device moved sda");
    a_ack_span: assert property (p_ack_span) else $error("device bit too short");
    a_ack_delay: assert property (p_ack_delay) else $error("device drive late");
    a_start_free: assert property (p_start_free) else $error("device held start");
    a_scl_low: assert property (p_scl_low) else $error("scl low too short");
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    a_wire_low: assert property (p_wire_low) else $error("sda not pulled low");
    c_dev_ack: cover property ($rose(sda_d_oe));
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
endmodule

// ==== bench/tb_top.sv ====
/*
 Bench: controller and device joined on one link, run through the
 controller's register port. Assumes the design package compiles first.
*/
`timescale 1ns/1ns
module tb_top;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic chk_rd = 1'h0;
    logic pend = 1'h0;
    logic [7:0] reg_rdata, addr_pointer, a, b, d, s;
    logic prot_unlocked, write_busy;
    logic [15:0] notes[$];
    logic [15:0] nt;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int seed = 32'hE293;
    // Arbitrary identifier value
    localparam logic [63:0] NID = 64'h0A1B2C_0102030405;
    always #5 clock = ~clock;
    eerk_if link();
    eerk_host #(.QUARTER(8)) u_eerk_host (.clock, .rst_n, .ce, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .bus(link.host));
    eerk_dev #(.WRITE_CYCLES(2000), .ID_KIND(eerk_pkg::ID_64), .NODE_ID(NID)) u_eerk_dev (
        .clock, .rst_n, .ce, .bus(link.dev), .addr_pointer, .prot_unlocked, .write_busy);
    eerk_props u_props (.clock, .rst_n, .scl_o(link.scl_o), .scl_oe(link.scl_oe),
        .sda_h_o(link.sda_h_o), .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o),
        .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            end_of_test();
        end
    end
    // Read data of a noted read stands one cycle after its strobe
    always @(posedge clock) begin
        if (pend) begin
            nt = notes.pop_front();
            check("read data", reg_rdata & nt[15:8], nt[7:0]);
        end
        pend <= reg_rd && chk_rd;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [1:0] ad, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] ad, input logic c);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        chk_rd <= c;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 s = reg_rdata;
    endtask
    // One link phase; e is the expected ack status or read byte
    task automatic op(input logic [7:0] cmd, input logic [7:0] tx, input logic [7:0] e);
        int k;
        if (cmd[eerk_pkg::CMD_WRITE]) wr(eerk_pkg::REG_TX, tx);
        wr(eerk_pkg::REG_CMD, cmd);
        s = 8'h01;
        for (k = 0; k < 3000 && s[eerk_pkg::STAT_BUSY] !== 1'h0; k++) begin
            rd(eerk_pkg::REG_STAT, 1'h0);
        end
        notes.push_back({cmd[eerk_pkg::CMD_WRITE] ? 8'h02 : 8'hFF, e});
        rd(cmd[eerk_pkg::CMD_WRITE] ? eerk_pkg::REG_STAT : eerk_pkg::REG_RX, 1'h1);
    endtask
    task automatic idle_wait;
        int k;
        for (k = 0; k < 3000 && write_busy !== 1'h0; k++) @(posedge clock);
    endtask
    task automatic wr_at(input logic [7:0] c, input logic [7:0] ad, input logic [7:0] v);
        op(8'h05, c, 8'h00);
        op(8'h04, ad, 8'h00);
        op(8'h06, v, 8'h00);
    endtask
    task automatic rd_at(input logic [7:0] c, input logic [7:0] ad, input logic [7:0] e);
        op(8'h05, c, 8'h00);
        op(8'h04, ad, 8'h00);
        op(8'h05, c | 8'h01, 8'h00);
        op(8'h1A, 8'h00, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'h1;
        a = 8'($random(seed));
        b = 8'($random(seed));
        d = 8'($random(seed));
        wr_at(8'hDE, eerk_pkg::KEY_ADDR, eerk_pkg::KEY_FIRST);
        wr_at(8'hDE, eerk_pkg::KEY_ADDR, 8'h33);
        wr_at(8'hAE, 8'hF0, d);
        idle_wait();
        rd_at(8'hAE, 8'hF0, NID[63:56]);
        rd_at(8'hDE, eerk_pkg::KEY_ADDR, 8'h00);
        wr_at(8'hDE, eerk_pkg::KEY_ADDR, eerk_pkg::KEY_FIRST);
        wr_at(8'hDE, eerk_pkg::KEY_ADDR, eerk_pkg::KEY_SECOND);
        check("unlocked", {7'h00, prot_unlocked}, 8'h01);
        wr_at(8'hAE, 8'hF0, d);
        check("unlocked", {7'h00, prot_unlocked}, 8'h00);
        idle_wait();
        rd_at(8'hAE, 8'hF0, d);
        rd_at(8'hAE, 8'hF1, NID[55:48]);
        wr_at(8'hAE, 8'hF1, ~d);
        idle_wait();
        rd_at(8'hAE, 8'hF1, NID[55:48]);
        wr_at(8'hAE, 8'h7F, a);
        check("busy", {7'h00, write_busy}, 8'h01);
        op(8'h07, 8'hAE, 8'h02);
        idle_wait();
        wr_at(8'hAE, 8'h00, b);
        idle_wait();
        op(8'h05, 8'hAE, 8'h00);
        op(8'h04, 8'h7F, 8'h00);
        op(8'h05, 8'hAF, 8'h00);
        op(8'h08, 8'h00, a);
        op(8'h1A, 8'h00, b);
        check("pointer", addr_pointer, 8'h01);
        op(8'h05, 8'hAF, 8'h00);
        op(8'h1A, 8'h00, eerk_pkg::ERASED);
        check("pointer", addr_pointer, 8'h02);
        op(8'h05, 8'hDE, 8'h00);
        op(8'h06, 8'h30, 8'h00);
        check("pointer", addr_pointer, 8'h30);
        op(8'h05, 8'hAE, 8'h00);
        op(8'h06, 8'h80, 8'h02);
        end_of_test();
    end
endmodule
